// ---- src/pra_consts.vh ----
// constants for the program and register address map block
// Behaviour
// - after reset, fetch starts at 0100H
// - interrupt vector read from bytes 0000H-0001H
// - bytes 003CH-003FH are boot option cells
// - erased FFH means undervoltage reset on, RC clock
// - program memory uses a 12-bit address
// - register file has its own 8-bit bus
// - memory ends at 07FFH or 0FFFH per variant
// - 0002H-00FFH besides option cells hold code
// - register 00H-BFH is general purpose space
// - upper 64 bytes: working and control registers
// - only page 0, no page select
// - 11 system and 15 peripheral control bytes
// - C0H-CFH is the common working area
`ifndef PRA_CONSTS_VH
`define PRA_CONSTS_VH

`define PRA_PA_W 12
`define PRA_RA_W 8
`define PRA_RESET_PC 12'h100
`define PRA_VEC_HI 12'h000
`define PRA_VEC_LO 12'h001
`define PRA_OPT_FIRST 12'h03c
`define PRA_OPT_LAST 12'h03f
`define PRA_OPT_VOLT 12'h03e
`define PRA_OPT_OSC 12'h03f
`define PRA_OPT_COUNT 3'h4
`define PRA_OPT_ERASED 8'hff
`define PRA_OPT_UNUSED 8'h00
`define PRA_VOLT_EN_BIT 7
`define PRA_OSC_RC_BIT 0
`define PRA_ROM_TOP_2K 12'h7ff
`define PRA_ROM_TOP_4K 12'hfff
`define PRA_FILL_BYTE 8'hff
`define PRA_GP_LAST 8'hbf
`define PRA_WORK_FIRST 8'hc0
`define PRA_WORK_LAST 8'hcf
`define PRA_SYS_FIRST 8'hd0
`define PRA_SYS_LAST 8'hda
`define PRA_PER_FIRST 8'he0
`define PRA_PER_LAST 8'hee
`define PRA_PAGE0 4'h0

`endif

// ---- src/pra_reg_decode.v ----
// register file address decoder with working register translation
`timescale 1ns/100ps
`include "pra_consts.vh"
module pra_reg_decode (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // register bus request
  input wire reg_req_in,
  input wire reg_direct_in,
  input wire [7:0] reg_addr_in,
  // decoded result
  output reg reg_ack_out,
  output reg [7:0] reg_eff_addr_out,
  output reg [3:0] reg_page_out,
  output reg sel_gp_out,
  output reg sel_work_out,
  output reg sel_sys_out,
  output reg sel_per_out,
  output reg unmapped_out,
  output reg invalid_mode_out
);

  function in_span;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_span = (a >= lo) && (a <= hi);
    end
  endfunction

  reg [7:0] eff;

  always @* begin
    // working mode carries a 4-bit index into the common area
    if (reg_direct_in) begin
      eff = reg_addr_in;
    end else begin
      eff = `PRA_WORK_FIRST | {4'h0, reg_addr_in[3:0]};
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_ack_out <= 1'b0;
      reg_eff_addr_out <= 8'h00;
      reg_page_out <= `PRA_PAGE0;
      sel_gp_out <= 1'b0;
      sel_work_out <= 1'b0;
      sel_sys_out <= 1'b0;
      sel_per_out <= 1'b0;
      unmapped_out <= 1'b0;
      invalid_mode_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_req_in;
      reg_eff_addr_out <= eff;
      // no page register exists, so gp space never moves
      reg_page_out <= `PRA_PAGE0;
      sel_gp_out <= reg_req_in && eff <= `PRA_GP_LAST;
      sel_work_out <= reg_req_in &&
        in_span(eff, `PRA_WORK_FIRST, `PRA_WORK_LAST);
      sel_sys_out <= reg_req_in &&
        in_span(eff, `PRA_SYS_FIRST, `PRA_SYS_LAST);
      sel_per_out <= reg_req_in &&
        in_span(eff, `PRA_PER_FIRST, `PRA_PER_LAST);
      unmapped_out <= reg_req_in && eff > `PRA_WORK_LAST &&
        !in_span(eff, `PRA_SYS_FIRST, `PRA_SYS_LAST) &&
        !in_span(eff, `PRA_PER_FIRST, `PRA_PER_LAST);
      invalid_mode_out <= reg_req_in && reg_direct_in &&
        in_span(eff, `PRA_WORK_FIRST, `PRA_WORK_LAST);
    end
  end

endmodule

// ---- src/pra_map.v ----
// program memory map, boot option loader and register map top
`timescale 1ns/100ps
`include "pra_consts.vh"
module pra_map #(
  parameter ROM_4K = 1
) (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // cpu fetch port
  input wire fetch_req_in,
  input wire [11:0] fetch_addr_in,
  input wire int_take_in,
  output reg cpu_ready_out,
  output reg [11:0] start_pc_out,
  output reg fetch_valid_out,
  output reg [7:0] fetch_data_out,
  output reg fetch_fault_out,
  output reg fetch_opt_cell_out,
  output reg vector_valid_out,
  output reg [11:0] vector_addr_out,
  // program memory port
  output reg rom_rd_out,
  output reg [11:0] rom_addr_out,
  input wire [7:0] rom_data_in,
  // boot option results
  output reg low_voltage_reset_en_out,
  output reg osc_internal_rc_out,
  output reg [7:0] opt_volt_byte_out,
  output reg [7:0] opt_osc_byte_out,
  output reg opt_unused_bad_out,
  // register bus
  input wire reg_req_in,
  input wire reg_direct_in,
  input wire [7:0] reg_addr_in,
  output wire reg_ack_out,
  output wire [7:0] reg_eff_addr_out,
  output wire [3:0] reg_page_out,
  output wire sel_gp_out,
  output wire sel_work_out,
  output wire sel_sys_out,
  output wire sel_per_out,
  output wire reg_unmapped_out,
  output wire reg_invalid_mode_out
);

  localparam [5:0] ST_BOOT = 6'b000001;
  localparam [5:0] ST_APPLY = 6'b000010;
  localparam [5:0] ST_RUN = 6'b000100;
  localparam [5:0] ST_VEC_A = 6'b001000;
  localparam [5:0] ST_VEC_B = 6'b010000;
  localparam [5:0] ST_VEC_C = 6'b100000;

  function [11:0] rom_top;
    input big;
    begin
      rom_top = big ? `PRA_ROM_TOP_4K : `PRA_ROM_TOP_2K;
    end
  endfunction

  function is_opt_cell;
    input [11:0] a;
    begin
      is_opt_cell = (a >= `PRA_OPT_FIRST) && (a <= `PRA_OPT_LAST);
    end
  endfunction

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [2:0] boot_idx_reg;
  reg [2:0] boot_idx_next;
  reg [11:0] cap_addr_reg;
  reg cap_boot_reg;
  reg pend_fetch_reg;
  reg pend_fault_reg;
  reg [7:0] vec_hi_reg;
  reg [11:0] opt_addr;

  // the sequencer owns the memory port until boot and vector reads end
  always @* begin
    state_next = state_reg;
    boot_idx_next = boot_idx_reg;
    case (state_reg)
      ST_BOOT: begin
        boot_idx_next = boot_idx_reg + 3'h1;
        if (boot_idx_reg == `PRA_OPT_COUNT - 3'h1) begin
          state_next = ST_APPLY;
        end
      end
      ST_APPLY: begin
        state_next = ST_RUN;
      end
      ST_RUN: begin
        if (int_take_in) begin
          state_next = ST_VEC_A;
        end
      end
      ST_VEC_A: begin
        state_next = ST_VEC_B;
      end
      ST_VEC_B: begin
        state_next = ST_VEC_C;
      end
      ST_VEC_C: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_BOOT;
        boot_idx_next = 3'h0;
      end
    endcase
  end

  always @* begin
    opt_addr = `PRA_OPT_FIRST + {9'h000, boot_idx_reg};
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_BOOT;
      boot_idx_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      boot_idx_reg <= boot_idx_next;
    end
  end

  // memory port: one read per cycle, data back one cycle later
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rom_rd_out <= 1'b0;
      rom_addr_out <= 12'h000;
      cap_addr_reg <= 12'h000;
      cap_boot_reg <= 1'b0;
      pend_fetch_reg <= 1'b0;
      pend_fault_reg <= 1'b0;
    end else begin
      rom_rd_out <= 1'b0;
      cap_boot_reg <= 1'b0;
      pend_fetch_reg <= 1'b0;
      pend_fault_reg <= 1'b0;
      case (state_reg)
        ST_BOOT: begin
          rom_rd_out <= 1'b1;
          rom_addr_out <= opt_addr;
          cap_addr_reg <= opt_addr;
          cap_boot_reg <= 1'b1;
        end
        ST_RUN: begin
          // an interrupt take wins over a fetch in the same cycle
          if (int_take_in) begin
            rom_rd_out <= 1'b0;
          end else if (fetch_req_in) begin
            pend_fetch_reg <= 1'b1;
            if (fetch_addr_in > rom_top(ROM_4K != 0)) begin
              pend_fault_reg <= 1'b1;
            end else begin
              rom_rd_out <= 1'b1;
              rom_addr_out <= fetch_addr_in;
            end
          end
        end
        ST_VEC_A: begin
          rom_rd_out <= 1'b1;
          rom_addr_out <= `PRA_VEC_HI;
        end
        ST_VEC_B: begin
          rom_rd_out <= 1'b1;
          rom_addr_out <= `PRA_VEC_LO;
        end
        default: begin
          rom_rd_out <= 1'b0;
        end
      endcase
    end
  end

  // boot option capture; erased defaults hold while reset is low
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opt_volt_byte_out <= `PRA_OPT_ERASED;
      opt_osc_byte_out <= `PRA_OPT_ERASED;
      opt_unused_bad_out <= 1'b0;
      low_voltage_reset_en_out <= 1'b1;
      osc_internal_rc_out <= 1'b1;
    end else begin
      if (cap_boot_reg) begin
        if (cap_addr_reg == `PRA_OPT_VOLT) begin
          opt_volt_byte_out <= rom_data_in;
        end
        if (cap_addr_reg == `PRA_OPT_OSC) begin
          opt_osc_byte_out <= rom_data_in;
        end
        // the unused cells are only watched, never acted upon
        if (cap_addr_reg < `PRA_OPT_VOLT &&
            rom_data_in != `PRA_OPT_UNUSED) begin
          opt_unused_bad_out <= 1'b1;
        end
      end
      if (state_reg == ST_APPLY) begin
        low_voltage_reset_en_out <=
          opt_volt_byte_out[`PRA_VOLT_EN_BIT];
        osc_internal_rc_out <= rom_data_in[`PRA_OSC_RC_BIT];
        opt_osc_byte_out <= rom_data_in;
      end
    end
  end

  // fetch answers and the cpu handshake
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_ready_out <= 1'b0;
      start_pc_out <= `PRA_RESET_PC;
      fetch_valid_out <= 1'b0;
      fetch_data_out <= 8'h00;
      fetch_fault_out <= 1'b0;
      fetch_opt_cell_out <= 1'b0;
    end else begin
      // ready rises only once options are applied
      cpu_ready_out <= (state_next == ST_RUN) &&
        !(state_reg == ST_RUN && int_take_in);
      start_pc_out <= `PRA_RESET_PC;
      fetch_valid_out <= pend_fetch_reg;
      fetch_fault_out <= pend_fault_reg;
      if (pend_fetch_reg) begin
        fetch_data_out <= pend_fault_reg ? `PRA_FILL_BYTE : rom_data_in;
        fetch_opt_cell_out <= is_opt_cell(rom_addr_out) &&
          !pend_fault_reg;
      end else begin
        fetch_opt_cell_out <= 1'b0;
      end
    end
  end

  // interrupt vector assembly, high byte first
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vec_hi_reg <= 8'h00;
      vector_valid_out <= 1'b0;
      vector_addr_out <= 12'h000;
    end else begin
      vector_valid_out <= 1'b0;
      if (state_reg == ST_VEC_B) begin
        vec_hi_reg <= rom_data_in;
      end
      if (state_reg == ST_VEC_C) begin
        vector_valid_out <= 1'b1;
        // upper nibble is dropped: the program bus is only 12 bits
        vector_addr_out <= {vec_hi_reg[3:0], rom_data_in};
      end
    end
  end

  pra_reg_decode u_reg_decode (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .reg_req_in(reg_req_in),
    .reg_direct_in(reg_direct_in),
    .reg_addr_in(reg_addr_in),
    .reg_ack_out(reg_ack_out),
    .reg_eff_addr_out(reg_eff_addr_out),
    .reg_page_out(reg_page_out),
    .sel_gp_out(sel_gp_out),
    .sel_work_out(sel_work_out),
    .sel_sys_out(sel_sys_out),
    .sel_per_out(sel_per_out),
    .unmapped_out(reg_unmapped_out),
    .invalid_mode_out(reg_invalid_mode_out)
  );

endmodule

// ---- bench/pra_rom_model.sv ----
// program memory model answering the block's read strobe
`timescale 1ns/100ps
module pra_rom_model (
  // memory port
  input wire clock_in,
  input wire rom_rd_in,
  input wire [11:0] rom_addr_in,
  // boot option contents chosen by the bench
  input wire [7:0] opt_volt_in,
  input wire [7:0] opt_osc_in,
  output reg [7:0] rom_data_out
);
  reg [7:0] held = 8'h00;
  always @(posedge clock_in) held <= rom_data_out;
  // idle bus toggles so stale data is never mistaken for a read
  always @* begin
    if (!rom_rd_in)
      rom_data_out = ~held;
    else if (rom_addr_in == 12'h03e)
      rom_data_out = opt_volt_in;
    else if (rom_addr_in == 12'h03f)
      rom_data_out = opt_osc_in;
    else if (rom_addr_in[11:1] == 11'h01e)
      rom_data_out = 8'h00;
    else
      rom_data_out = rom_addr_in[7:0] ^ 8'h5a;
  end
endmodule

// ---- bench/pra_map_chk.sv ----
// concurrent checks on the address map block ports
`timescale 1ns/100ps
module pra_map_chk #(
  parameter ROM_4K = 1
) (
  // clock, reset and fetch side
  input wire clock_in, rst_n_in, fetch_req_in, int_take_in,
  input wire [11:0] fetch_addr_in, start_pc_out, rom_addr_out,
  input wire cpu_ready_out, fetch_valid_out, fetch_fault_out,
  input wire fetch_opt_cell_out, vector_valid_out, rom_rd_out,
  input wire [7:0] fetch_data_out, opt_volt_byte_out, opt_osc_byte_out,
  input wire low_voltage_reset_en_out, osc_internal_rc_out,
  // register side
  input wire reg_req_in, reg_direct_in,
  input wire [7:0] reg_addr_in, reg_eff_addr_out,
  input wire [3:0] reg_page_out,
  input wire reg_ack_out, sel_gp_out, sel_work_out, sel_sys_out,
  input wire sel_per_out, reg_invalid_mode_out
);
  localparam [11:0] TOP = ROM_4K ? 12'hfff : 12'h7ff;
  wire take = cpu_ready_out && fetch_req_in && !int_take_in;
  wire [7:0] ea = reg_direct_in ? reg_addr_in : {4'hc, reg_addr_in[3:0]};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  reset_pc_a: assert property (start_pc_out == 12'h100)
    else $error("start address wrong");
  fetch_lat_a: assert property (take |-> ##2 fetch_valid_out &&
    fetch_fault_out == ($past(fetch_addr_in, 2) > TOP))
    else $error("fetch answer wrong");
  opt_cell_a: assert property (take |-> ##2 fetch_opt_cell_out ==
    ($past(fetch_addr_in, 2) >= 12'h03c && $past(fetch_addr_in, 2) <= 12'h03f))
    else $error("option cell flag wrong");
  rom_range_a: assert property (rom_rd_out |->
    rom_addr_out <= TOP) else $error("read past memory top");
  vector_seq_a: assert property (cpu_ready_out && int_take_in |=>
    !cpu_ready_out ##1 rom_rd_out && rom_addr_out == 12'h000
    ##1 rom_addr_out == 12'h001 ##1 vector_valid_out)
    else $error("vector sequence wrong");
  opts_applied_a: assert property (cpu_ready_out |->
    low_voltage_reset_en_out == opt_volt_byte_out[7] &&
    osc_internal_rc_out == opt_osc_byte_out[0])
    else $error("options not applied");
  reg_ack_a: assert property (reg_req_in |=>
    reg_ack_out && reg_page_out == 4'h0) else $error("register ack wrong");
  gp_space_a: assert property (reg_req_in && ea <= 8'hbf |=>
    sel_gp_out && !sel_work_out) else $error("general space wrong");
  work_xlate_a: assert property (reg_req_in && !reg_direct_in |=>
    sel_work_out && !reg_invalid_mode_out &&
    reg_eff_addr_out == {4'hc, $past(reg_addr_in[3:0])})
    else $error("working translation wrong");
  bad_mode_a: assert property (reg_req_in && reg_direct_in &&
    reg_addr_in[7:4] == 4'hc |=> reg_invalid_mode_out)
    else $error("direct working access not flagged");
  sys_ctrl_a: assert property (reg_req_in && ea >= 8'hd0 &&
    ea <= 8'hda |=> sel_sys_out) else $error("system control decode wrong");
  per_ctrl_a: assert property (reg_req_in && ea >= 8'he0 &&
    ea <= 8'hee |=> sel_per_out) else $error("peripheral decode wrong");
  cover property (fetch_fault_out);
  cover property (vector_valid_out);
  cover property (reg_invalid_mode_out);
endmodule
bind pra_map pra_map_chk #(.ROM_4K(ROM_4K)) i_chk (.*);

// ---- bench/tb_top.sv ----
// self-checking bench for the address map block
`timescale 1ns/100ps
module tb_top;
  reg clock_in = 0, rst_n_in = 0, fetch_req_in = 0, int_take_in = 0;
  reg reg_req_in = 0, reg_direct_in = 0;
  reg [11:0] fetch_addr_in = 0;
  reg [7:0] reg_addr_in = 0, volt = 8'hff, osc = 8'hff;
  reg [31:0] r;
  wire cpu_ready_out, fetch_valid_out, fetch_fault_out, fetch_opt_cell_out;
  wire vector_valid_out, rom_rd_out, low_voltage_reset_en_out;
  wire osc_internal_rc_out, opt_unused_bad_out, reg_ack_out, sel_gp_out;
  wire sel_work_out, sel_sys_out, sel_per_out, reg_unmapped_out;
  wire reg_invalid_mode_out;
  wire [11:0] start_pc_out, vector_addr_out, rom_addr_out;
  wire [7:0] fetch_data_out, rom_data_in, opt_volt_byte_out;
  wire [7:0] opt_osc_byte_out, reg_eff_addr_out;
  wire [3:0] reg_page_out;
  integer err_count = 0, checks = 0, cyc = 0, i, seed = 32'h85c17426;
  reg [9:0] fq[$];
  // 2K variant so the upper half of the address space faults
  pra_map #(.ROM_4K(0)) i_dut (.*);
  pra_rom_model i_rom (.clock_in(clock_in), .rom_rd_in(rom_rd_out),
    .rom_addr_in(rom_addr_out), .opt_volt_in(volt), .opt_osc_in(osc),
    .rom_data_out(rom_data_in));
  always #20 clock_in = ~clock_in;
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  function [14:0] rexp(input d, input [7:0] a);
    reg [7:0] e;
    reg s, p;
    begin
      e = d ? a : {4'hc, a[3:0]};
      s = e >= 8'hd0 && e <= 8'hda;
      p = e >= 8'he0 && e <= 8'hee;
      rexp = {1'b1, e, e <= 8'hbf, e[7:4] == 4'hc, s, p,
        e >= 8'hd0 && !s && !p, d && e[7:4] == 4'hc};
    end
  endfunction
  function [9:0] fexp(input [11:0] a);
    begin
      fexp = {a > 12'h7ff, a >= 12'h03c && a <= 12'h03f, a[7:0] ^ 8'h5a};
      if (a > 12'h7ff)
        fexp[7:0] = 8'hff;
      else if (a == 12'h03e)
        fexp[7:0] = volt;
      else if (a == 12'h03f)
        fexp[7:0] = osc;
      else if (a[11:1] == 11'h01e)
        fexp[7:0] = 8'h00;
    end
  endfunction
  task boot(input [7:0] l, input [7:0] o);
    begin
      volt = l;
      osc = o;
      rst_n_in = 0;
      repeat (8) @(posedge clock_in);
      #1 rst_n_in = 1;
      i = 0;
      while (cpu_ready_out !== 1'b1 && i < 20) begin
        @(posedge clock_in);
        #1 i = i + 1;
      end
      chk(start_pc_out, 12'h100);
      chk({low_voltage_reset_en_out, osc_internal_rc_out, opt_unused_bad_out},
        {l[7], o[0], 1'b0});
      // ready must come after four option reads and one apply cycle
      chk({cpu_ready_out, i[7:0]}, {1'b1, 8'h05});
      chk({opt_volt_byte_out, opt_osc_byte_out}, {l, o});
    end
  endtask
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (fetch_valid_out === 1'b1)
      chk({fetch_fault_out, fetch_opt_cell_out, fetch_data_out},
        fq.pop_front());
    if (cyc > 3000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  initial begin
    boot(8'hff, 8'hff);
    // every direct address, then random working-mode accesses
    for (i = 0; i < 288; i = i + 1) begin
      r = $random(seed);
      reg_req_in = 1;
      reg_direct_in = i < 256;
      reg_addr_in = i < 256 ? i[7:0] : r[7:0];
      @(posedge clock_in);
      #1 chk({reg_ack_out, reg_eff_addr_out, sel_gp_out, sel_work_out,
        sel_sys_out, sel_per_out, reg_unmapped_out, reg_invalid_mode_out},
        rexp(reg_direct_in, reg_addr_in));
    end
    reg_req_in = 0;
    // back-to-back fetches: option cells, memory edge, then random
    for (i = 0; i < 64; i = i + 1) begin
      r = $random(seed);
      fetch_req_in = 1;
      fetch_addr_in = i < 4 ? {10'h00f, i[1:0]} : i == 4 ? 12'h7ff :
        i == 5 ? 12'h800 : r[11:0];
      fq.push_back(fexp(fetch_addr_in));
      @(posedge clock_in);
      #1;
    end
    fetch_req_in = 0;
    repeat (3) @(posedge clock_in);
    #1 chk(fq.size(), 16'h0);
    int_take_in = 1;
    // a fetch in the same cycle as the take must get no answer
    fetch_req_in = 1;
    fetch_addr_in = 12'h123;
    @(posedge clock_in);
    #1 int_take_in = 0;
    fetch_req_in = 0;
    i = 0;
    while (vector_valid_out !== 1'b1 && i < 10) begin
      @(posedge clock_in);
      #1 i = i + 1;
    end
    chk(vector_addr_out, 12'ha5b);
    r = $random(seed);
    boot(r[7:0], r[15:8]);
    wrap_up;
  end
endmodule
